// *** hw/shear_seq_pkg.sv ***
// Shared constants and types for the shear axis mode sequencer.
package shear_seq_pkg;
    // System clock rate and the millisecond tick derived from it.
    localparam int CLOCK_KHZ = 125_000;
    localparam int TICK_TIME_MS = 1;
    localparam int DIV_W = 17;
    // Times counted in milliseconds.
    localparam logic [15:0] HOLD_TIME_MS = 16'h07d0;
    localparam logic [15:0] MS_PER_SEC = 16'h03e8;
    localparam logic [15:0] BLINK_MS = 16'h00fa;
    localparam logic [15:0] MS_MAX = 16'hffff;
    // Widths and depths.
    localparam int POS_W = 32;
    localparam int PROG_W = 10;
    localparam int PROG_COUNT = 1000;
    localparam int SET_W = 10;
    localparam int SET_DEPTH = 1024;
    localparam int PMODE_W = 2;
    localparam int QTY_W = 16;
    localparam int CUT_W = 16;
    // Homing mode selections.
    localparam logic [2:0] HOME_PARAM = 3'h1;
    localparam logic [2:0] HOME_TARGET = 3'h2;
    localparam logic [2:0] HOME_POS_IDX = 3'h3;
    localparam logic [2:0] HOME_NEG_IDX = 3'h4;
    localparam logic [2:0] HOME_POS_SW = 3'h5;
    localparam logic [2:0] HOME_NEG_SW = 3'h6;
    // Reset value of positions.
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    // Operating modes.
    typedef enum logic [1:0] {
        OP_MANUAL,
        OP_SINGLE,
        OP_PROGRAM
    } op_mode_t;
    // Field under the edit cursor.
    typedef enum logic [2:0] {
        FLD_TARGET,
        FLD_BLOCK,
        FLD_PMODE,
        FLD_SETNUM,
        FLD_QTY,
        FLD_CUTLEN
    } field_t;
endpackage

// *** hw/hold_timer.sv ***
// Millisecond hold timer that restarts whenever its level drops.
module hold_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic level,
    input wire logic [15:0] limit,
    output logic over
);
    typedef struct packed {
        logic [15:0] cnt;
        logic over;
    } hold_state_t;

    hold_state_t cur;
    hold_state_t next_cur;

    always_comb begin
        next_cur = cur;
        if (!level) begin
            next_cur.cnt = '0;
        end else if (tick && cur.cnt != shear_seq_pkg::MS_MAX) begin
            next_cur.cnt = cur.cnt + 16'h0001;
        end
        // Only a count strictly past the limit counts as held long enough.
        next_cur.over = level && (next_cur.cnt > limit);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign over = cur.over;

    a_hold_restart: assert property (@(posedge clock) disable iff (!rst_n)
        !level |=> !over && cur.cnt == '0)
        else $error("Hold timer did not restart on release.");
endmodule

// *** hw/shear_axis_mode_sequencer.sv ***
// Mode sequencer for one shear axis: jog, single, program and homing.
//
// Contract
// - Jog keys move axis while held.
// - Creep first, fast after configured seconds.
// - Blink cursor while editing; adopt on enter.
// - Up to a thousand selectable programs.
// - One start runs all sets in turn.
// - Block number asked only on first set.
// - Entered value stored at once on enter.
// - End key on set field marks end.
// - Run sets in order, halt after end.
// - Stop aborts, keeps set; start resumes there.
// - Home mode one loads stored reference.
// - Home mode two loads target position.
// - Modes three/four: limit switch, index pulse.
// - Modes five/six: reference point switch, no index.
// - Homing run only on two-second hold.
// - Homing output high during whole run.
// - Switch hit stops, dwell, then reverse.
// - Switch release arms index; index loads reference.
// - External stop halts and refuses starts.
// - External start equals start button.
// - Modes five/six use reference point input.
module shear_axis_mode_sequencer #(
    parameter int MS_CYCLES = shear_seq_pkg::CLOCK_KHZ *
        shear_seq_pkg::TICK_TIME_MS
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire shear_seq_pkg::op_mode_t op_mode,
    input wire logic [2:0] homing_mode,
    input wire logic [3:0] creep_delay_s,
    input wire logic [15:0] dwell_ms,
    input wire logic [31:0] ref_value,
    input wire logic jog_minus_key,
    input wire logic jog_plus_key,
    input wire logic teach_home_key,
    input wire logic enter_key,
    input wire logic start_key,
    input wire logic stop_key,
    input wire logic ext_start,
    input wire logic ext_stop,
    input wire logic ext_ref,
    input wire logic ref_point,
    input wire logic limit_pos,
    input wire logic limit_neg,
    input wire logic index_pulse,
    input wire logic pos_reached,
    input wire logic editing,
    input wire logic prog_select,
    input wire shear_seq_pkg::field_t edit_field,
    input wire logic [31:0] edit_value,
    output logic drive_plus,
    output logic drive_minus,
    output logic drive_fast,
    output logic positioning,
    output logic [31:0] run_target,
    output logic homing_active,
    output logic pos_load,
    output logic [31:0] pos_load_value,
    output logic cursor_blink,
    output logic block_request,
    output logic program_active,
    output logic prog_end,
    output logic [9:0] prog_number,
    output logic [9:0] set_index
);
    typedef logic [shear_seq_pkg::SET_W-1:0] set_t;
    typedef logic [shear_seq_pkg::DIV_W-1:0] div_t;
    typedef logic [shear_seq_pkg::PROG_W-1:0] prog_t;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_POS,
        ST_RUN,
        ST_SEEK,
        ST_DWELL,
        ST_REV,
        ST_INDEX
    } seq_state_t;

    typedef struct packed {
        seq_state_t st;
        div_t div;
        logic tick;
        logic [15:0] dwell_cnt;
        logic [15:0] blink_cnt;
        logic blink;
        logic hold_prev;
        logic ref_prev;
        logic start_prev;
        logic jp_prev;
        logic jm_prev;
        logic th_prev;
        logic dir;
        logic [31:0] target;
        logic [31:0] run_target;
        prog_t prog;
        set_t base;
        set_t set_idx;
        logic drive_plus;
        logic drive_minus;
        logic drive_fast;
        logic positioning;
        logic homing_active;
        logic pos_load;
        logic [31:0] pos_load_value;
        logic cursor_blink;
        logic block_request;
        logic program_active;
        logic prog_end;
    } seq_reg_t;

    function automatic set_t set_addr(input set_t base, input set_t idx);
        set_addr = set_t'(base + idx);
    endfunction

    logic [1:0] rst_sync;
    logic rst_n;
    seq_reg_t cur;
    seq_reg_t next_cur;
    logic hold_over;
    logic creep_over;
    logic hold_level;
    logic creep_level;
    logic [15:0] creep_limit;
    logic end_ctx;
    logic [31:0] set_target [0:shear_seq_pkg::SET_DEPTH-1];
    logic [1:0] set_pmode [0:shear_seq_pkg::SET_DEPTH-1];
    logic [15:0] set_qty [0:shear_seq_pkg::SET_DEPTH-1];
    logic [15:0] set_cut [0:shear_seq_pkg::SET_DEPTH-1];
    logic set_end [0:shear_seq_pkg::SET_DEPTH-1];
    set_t prog_base [0:shear_seq_pkg::PROG_COUNT-1];
    set_t addr;
    logic entry_en;
    logic end_mark;
    logic start_ev;
    logic stop_any;
    logic home_sw;

    // Reset is released through two flops so every flop reset by rst_n leaves it together; the set memory has no reset except the end flags.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end
    assign rst_n = rst_sync[1];

    assign addr = set_addr(cur.base, cur.set_idx);
    assign end_ctx = op_mode == shear_seq_pkg::OP_PROGRAM &&
        edit_field == shear_seq_pkg::FLD_SETNUM;
    // The end key shares the homing key, so it never counts as a hold there.
    assign hold_level = teach_home_key && !end_ctx;
    assign creep_level = op_mode == shear_seq_pkg::OP_MANUAL &&
        cur.st == ST_IDLE && (jog_plus_key ^ jog_minus_key);
    assign creep_limit = 16'(creep_delay_s) * shear_seq_pkg::MS_PER_SEC;
    assign entry_en = op_mode == shear_seq_pkg::OP_PROGRAM &&
        cur.st == ST_IDLE && enter_key && !prog_select;
    assign end_mark = end_ctx && cur.st == ST_IDLE && teach_home_key &&
        !cur.th_prev;
    assign start_ev = (start_key || ext_start) && !cur.start_prev;
    assign stop_any = stop_key || ext_stop;
    // Modes five and six look at the reference point input instead.
    assign home_sw = (homing_mode == shear_seq_pkg::HOME_POS_SW ||
        homing_mode == shear_seq_pkg::HOME_NEG_SW) ? ref_point :
        (cur.dir ? limit_pos : limit_neg);

    hold_timer home_hold (
        .clock(clock),
        .rst_n(rst_n),
        .tick(cur.tick),
        .level(hold_level),
        .limit(shear_seq_pkg::HOLD_TIME_MS),
        .over(hold_over)
    );

    hold_timer creep_hold (
        .clock(clock),
        .rst_n(rst_n),
        .tick(cur.tick),
        .level(creep_level),
        .limit(creep_limit),
        .over(creep_over)
    );

    // Set memory has no reset except the end flags, which steer the run.
    always_ff @(posedge clock) begin
        if (entry_en) begin
            case (edit_field)
                shear_seq_pkg::FLD_TARGET: set_target[addr] <= edit_value;
                shear_seq_pkg::FLD_PMODE: set_pmode[addr] <= edit_value[1:0];
                shear_seq_pkg::FLD_QTY: set_qty[addr] <= edit_value[15:0];
                shear_seq_pkg::FLD_CUTLEN: set_cut[addr] <= edit_value[15:0];
                shear_seq_pkg::FLD_BLOCK: begin
                    if (cur.set_idx == '0) begin
                        prog_base[cur.prog] <= set_t'(edit_value);
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < shear_seq_pkg::SET_DEPTH; i++) begin
                set_end[i] <= '0;
            end
        end else if (end_mark) begin
            set_end[addr] <= '1;
        end else if (entry_en && edit_field == shear_seq_pkg::FLD_TARGET) begin
            set_end[addr] <= '0;
        end
    end

    always_comb begin
        next_cur = cur;
        next_cur.pos_load = '0;
        next_cur.tick = cur.div == div_t'(MS_CYCLES - 1);
        next_cur.div = next_cur.tick ? '0 : div_t'(cur.div + 1'h1);
        next_cur.hold_prev = hold_over;
        next_cur.ref_prev = ext_ref;
        next_cur.start_prev = start_key || ext_start;
        next_cur.jp_prev = jog_plus_key;
        next_cur.jm_prev = jog_minus_key;
        next_cur.th_prev = teach_home_key;
        if (!editing) begin
            next_cur.blink_cnt = '0;
            next_cur.blink = '0;
        end else if (cur.tick) begin
            if (cur.blink_cnt == shear_seq_pkg::BLINK_MS - 16'h0001) begin
                next_cur.blink_cnt = '0;
                next_cur.blink = !cur.blink;
            end else begin
                next_cur.blink_cnt = cur.blink_cnt + 16'h0001;
            end
        end
        case (cur.st)
            ST_IDLE: begin
                if (op_mode == shear_seq_pkg::OP_SINGLE && enter_key &&
                    edit_field == shear_seq_pkg::FLD_TARGET) begin
                    next_cur.target = edit_value;
                end
                if (op_mode == shear_seq_pkg::OP_PROGRAM) begin
                    if (enter_key && prog_select &&
                        edit_value < shear_seq_pkg::PROG_COUNT) begin
                        next_cur.prog = prog_t'(edit_value);
                        next_cur.base = prog_base[prog_t'(edit_value)];
                        next_cur.set_idx = '0;
                    end else if (entry_en && cur.set_idx == '0 &&
                        edit_field == shear_seq_pkg::FLD_BLOCK) begin
                        // Later entries land in the new block at once.
                        next_cur.base = set_t'(edit_value);
                    end else if (entry_en &&
                        edit_field == shear_seq_pkg::FLD_SETNUM) begin
                        next_cur.set_idx = set_t'(edit_value);
                    end else if (jog_plus_key && !cur.jp_prev) begin
                        next_cur.set_idx = set_t'(cur.set_idx + 1'h1);
                    end else if (jog_minus_key && !cur.jm_prev) begin
                        next_cur.set_idx = set_t'(cur.set_idx - 1'h1);
                    end
                end
                if ((homing_mode == shear_seq_pkg::HOME_PARAM ||
                    homing_mode == shear_seq_pkg::HOME_TARGET) &&
                    ((ext_ref && !cur.ref_prev) ||
                    (hold_over && !cur.hold_prev))) begin
                    next_cur.pos_load = '1;
                    next_cur.pos_load_value =
                        (homing_mode == shear_seq_pkg::HOME_PARAM) ?
                        ref_value : cur.target;
                end else if (homing_mode >= shear_seq_pkg::HOME_POS_IDX &&
                    homing_mode <= shear_seq_pkg::HOME_NEG_SW &&
                    hold_over && !cur.hold_prev && !stop_any) begin
                    next_cur.st = ST_SEEK;
                    next_cur.dir = homing_mode == shear_seq_pkg::HOME_POS_IDX
                        || homing_mode == shear_seq_pkg::HOME_POS_SW;
                end else if (start_ev && !stop_any) begin
                    if (op_mode == shear_seq_pkg::OP_SINGLE) begin
                        next_cur.st = ST_POS;
                        next_cur.run_target = cur.target;
                    end else if (op_mode == shear_seq_pkg::OP_PROGRAM) begin
                        next_cur.st = ST_RUN;
                        next_cur.prog_end = '0;
                    end
                end
            end
            ST_POS: begin
                if (stop_any || pos_reached) begin
                    next_cur.st = ST_IDLE;
                end
            end
            ST_RUN: begin
                next_cur.run_target = set_target[addr];
                if (stop_any) begin
                    next_cur.st = ST_IDLE;
                end else if (pos_reached && set_end[addr]) begin
                    next_cur.st = ST_IDLE;
                    next_cur.prog_end = '1;
                end else if (pos_reached) begin
                    next_cur.set_idx = set_t'(cur.set_idx + 1'h1);
                end
            end
            ST_SEEK: begin
                if (home_sw) begin
                    next_cur.st = ST_DWELL;
                    next_cur.dwell_cnt = '0;
                end
            end
            ST_DWELL: begin
                if (cur.dwell_cnt >= dwell_ms) begin
                    next_cur.st = ST_REV;
                end else if (cur.tick) begin
                    next_cur.dwell_cnt = cur.dwell_cnt + 16'h0001;
                end
            end
            ST_REV: begin
                if (!home_sw) begin
                    if (homing_mode == shear_seq_pkg::HOME_POS_SW ||
                        homing_mode == shear_seq_pkg::HOME_NEG_SW) begin
                        next_cur.st = ST_IDLE;
                        next_cur.pos_load = '1;
                        next_cur.pos_load_value = ref_value;
                    end else begin
                        next_cur.st = ST_INDEX;
                    end
                end
            end
            ST_INDEX: begin
                if (index_pulse) begin
                    next_cur.st = ST_IDLE;
                    next_cur.pos_load = '1;
                    next_cur.pos_load_value = ref_value;
                end
            end
            default: next_cur.st = ST_IDLE;
        endcase
        if (stop_any && cur.st >= ST_SEEK) begin
            next_cur.st = ST_IDLE;
        end
        // Jogging with both keys held is ignored rather than guessed.
        next_cur.drive_plus = (next_cur.st == ST_IDLE && creep_level &&
            jog_plus_key) || (next_cur.st == ST_SEEK && next_cur.dir) ||
            ((next_cur.st == ST_REV || next_cur.st == ST_INDEX) &&
            !next_cur.dir);
        next_cur.drive_minus = (next_cur.st == ST_IDLE && creep_level &&
            jog_minus_key) || (next_cur.st == ST_SEEK && !next_cur.dir) ||
            ((next_cur.st == ST_REV || next_cur.st == ST_INDEX) &&
            next_cur.dir);
        next_cur.drive_fast = next_cur.st == ST_IDLE && creep_level &&
            creep_over;
        next_cur.positioning = next_cur.st == ST_POS || next_cur.st == ST_RUN;
        next_cur.homing_active = next_cur.st >= ST_SEEK;
        next_cur.cursor_blink = editing && next_cur.blink;
        next_cur.program_active = op_mode == shear_seq_pkg::OP_PROGRAM;
        next_cur.block_request = op_mode == shear_seq_pkg::OP_PROGRAM &&
            !prog_select && next_cur.set_idx == '0;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign drive_plus = cur.drive_plus;
    assign drive_minus = cur.drive_minus;
    assign drive_fast = cur.drive_fast;
    assign positioning = cur.positioning;
    assign run_target = cur.run_target;
    assign homing_active = cur.homing_active;
    assign pos_load = cur.pos_load;
    assign pos_load_value = cur.pos_load_value;
    assign cursor_blink = cur.cursor_blink;
    assign block_request = cur.block_request;
    assign program_active = cur.program_active;
    assign prog_end = cur.prog_end;
    assign prog_number = cur.prog;
    assign set_index = cur.set_idx;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_stop_halts_move: assert property (stop_any |=> !positioning)
        else $error("Positioning continued under stop.");
    a_fast_after_creep: assert property (drive_fast |-> $past(creep_over))
        else $error("Fast speed before creep delay elapsed.");
    a_hold_starts_run: assert property ($rose(homing_active) |->
        $past(hold_over) && !$past(cur.hold_prev))
        else $error("Homing run started without a long hold.");
    a_dwell_no_drive: assert property (cur.st == ST_DWELL |->
        !drive_plus && !drive_minus)
        else $error("Axis driven during dwell.");
    a_index_loads_ref: assert property ((cur.st == ST_INDEX &&
        index_pulse && !stop_any) |=> pos_load &&
        pos_load_value == $past(ref_value) && !homing_active)
        else $error("Index pulse did not load the reference.");
    a_end_halts_run: assert property ((cur.st == ST_RUN && pos_reached &&
        set_end[addr] && !stop_any) |=> prog_end && !positioning &&
        $stable(set_index))
        else $error("Run did not halt at the end marker.");
    a_stop_keeps_set: assert property ((cur.st == ST_RUN && stop_any) |=>
        $stable(set_index) && cur.st == ST_IDLE)
        else $error("Stop lost the current set.");
    a_mode1_ref_load: assert property ((cur.st == ST_IDLE &&
        homing_mode == shear_seq_pkg::HOME_PARAM && ext_ref &&
        !cur.ref_prev) |=> pos_load && pos_load_value == $past(ref_value))
        else $error("Mode one did not load the stored reference.");
    a_blink_off: assert property (!editing |=> !cursor_blink)
        else $error("Cursor blinks outside editing.");

    c_prog_end: cover property ($rose(prog_end));
    c_index_home: cover property (cur.st == ST_INDEX ##1 pos_load);
    c_fast_jog: cover property ($rose(drive_fast));
    c_single_move: cover property (cur.st == ST_POS && pos_reached);
endmodule

// *** sim/shear_axis_partner.sv ***
// Behavioural axis drive with limit switches and an encoder index.
module shear_axis_partner (
    input wire logic clock,
    input wire logic positioning,
    input wire logic homing_active,
    input wire logic drive_plus,
    input wire logic drive_minus,
    output logic pos_reached,
    output logic limit_pos,
    output logic limit_neg,
    output logic ref_point,
    output logic index_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_cnt = 0;
    int axis = 0;
    // The axis only travels in homing runs, so jogging never trips a switch.
    always @(posedge clock) begin
        run_cnt <= (positioning && !pos_reached) ? run_cnt + 1 : 0;
        if (homing_active && drive_plus)
            axis <= axis + 1;
        if (homing_active && drive_minus)
            axis <= axis - 1;
    end
    // Each move takes six cycles, long enough for a stop to land first.
    assign pos_reached = run_cnt == 6;
    assign limit_pos = axis >= 20;
    assign limit_neg = axis <= -20;
    // The reference point sits inside the negative limit, so it trips first.
    assign ref_point = axis <= -10;
    assign index_pulse = drive_minus && (axis % 8) == 0;
endmodule

// *** sim/test_shear_axis_mode_sequencer.sv ***
// Self-checking bench for the shear axis mode sequencer.
module test_shear_axis_mode_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0;
    logic rst_b = 0;
    shear_seq_pkg::op_mode_t op_mode = shear_seq_pkg::OP_MANUAL;
    shear_seq_pkg::field_t edit_field = shear_seq_pkg::FLD_TARGET;
    logic [2:0] homing_mode = 3'h0;
    logic [31:0] ref_value = 32'h0000_0abc;
    logic [31:0] edit_value = 32'h0000_0000;
    logic [7:0] kv = 8'h00;
    logic jog_hold = 0, home_hold = 0, ext_stop = 0;
    logic editing = 0, prog_select = 0;
    logic pos_reached, limit_pos, limit_neg, index_pulse, drive_plus;
    logic ref_point;
    logic drive_minus, drive_fast, positioning, homing_active, pos_load;
    logic cursor_blink, block_request, program_active, prog_end;
    logic [31:0] run_target, pos_load_value, last_load;
    logic [9:0] prog_number, set_index;
    int failures = 0, samples_checked = 0, cycles = 0, loads = 0, i, n;

    shear_axis_mode_sequencer #(.MS_CYCLES(10)) i_shear_axis_mode_sequencer (
        .clock(clock), .rst_b(rst_b), .op_mode(op_mode),
        .homing_mode(homing_mode), .creep_delay_s(4'h1),
        .dwell_ms(16'h0003), .ref_value(ref_value),
        .jog_minus_key(kv[3]), .jog_plus_key(kv[2] | jog_hold),
        .teach_home_key(kv[4] | home_hold), .enter_key(kv[0]),
        .start_key(kv[1]), .stop_key(kv[6]), .ext_start(kv[5]),
        .ext_stop(ext_stop), .ext_ref(kv[7]), .ref_point(ref_point),
        .limit_pos(limit_pos), .limit_neg(limit_neg),
        .index_pulse(index_pulse), .pos_reached(pos_reached),
        .editing(editing), .prog_select(prog_select),
        .edit_field(edit_field), .edit_value(edit_value),
        .drive_plus(drive_plus), .drive_minus(drive_minus),
        .drive_fast(drive_fast), .positioning(positioning),
        .run_target(run_target), .homing_active(homing_active),
        .pos_load(pos_load), .pos_load_value(pos_load_value),
        .cursor_blink(cursor_blink), .block_request(block_request),
        .program_active(program_active), .prog_end(prog_end),
        .prog_number(prog_number), .set_index(set_index));

    shear_axis_partner i_shear_axis_partner (
        .clock(clock), .positioning(positioning),
        .homing_active(homing_active), .drive_plus(drive_plus),
        .drive_minus(drive_minus), .pos_reached(pos_reached),
        .limit_pos(limit_pos), .limit_neg(limit_neg),
        .index_pulse(index_pulse), .ref_point(ref_point));

    always #4 clock = ~clock;

    // The load pulse lasts one cycle, so it is caught where it settles.
    always @(negedge clock) begin
        cycles++;
        if (pos_load === 1'b1) begin
            loads++;
            last_load = pos_load_value;
        end
        if (cycles == 90000) begin
            failures++;
            test_done();
        end
    end

    // Wide enough for a status bit packed beside a full position.
    task chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Key bits: enter, start, plus, minus, home, ext start, stop, ext ref.
    task tap(input int k);
        kv[k] = 1'b1;
        @(negedge clock);
        kv = 8'h00;
        repeat (2) @(negedge clock);
    endtask

    task ent(input shear_seq_pkg::field_t f, input logic [31:0] v);
        edit_field = f;
        edit_value = v;
        tap(0);
    endtask

    task t_single;
        op_mode = shear_seq_pkg::OP_SINGLE;
        editing = 1;
        for (i = 0; i < 3000 && cursor_blink !== 1'b1; i++) @(negedge clock);
        chk(cursor_blink, 1);
        ent(shear_seq_pkg::FLD_TARGET, 32'h0000_1234);
        edit_value = 32'h0000_5555;
        editing = 0;
        tap(5);
        chk(positioning, 1);
        chk(run_target, 32'h0000_1234);
        for (i = 0; i < 20 && positioning === 1'b1; i++) @(negedge clock);
    endtask

    task t_ref;
        op_mode = shear_seq_pkg::OP_MANUAL;
        homing_mode = shear_seq_pkg::HOME_PARAM;
        tap(7);
        chk(last_load, ref_value);
        homing_mode = shear_seq_pkg::HOME_TARGET;
        tap(7);
        chk(last_load, 32'h0000_1234);
        homing_mode = shear_seq_pkg::HOME_POS_IDX;
        tap(7);
        chk(homing_active, 0);
        chk(loads, 2);
    endtask

    task t_program;
        op_mode = shear_seq_pkg::OP_PROGRAM;
        prog_select = 1;
        ent(shear_seq_pkg::FLD_TARGET, 32'h0000_03e7);
        ent(shear_seq_pkg::FLD_TARGET, 32'h0000_03e8);
        prog_select = 0;
        @(negedge clock);
        chk(prog_number, 10'h3e7);
        chk({block_request, program_active}, 2'b11);
        ent(shear_seq_pkg::FLD_BLOCK, 32'h0000_0010);
        ent(shear_seq_pkg::FLD_TARGET, 32'h0000_0111);
        tap(2);
        chk({set_index, block_request}, 11'h002);
        ent(shear_seq_pkg::FLD_TARGET, 32'h0000_0222);
        edit_field = shear_seq_pkg::FLD_SETNUM;
        tap(4);
        tap(3);
        ext_stop = 1;
        tap(1);
        chk(positioning, 0);
        ext_stop = 0;
        tap(1);
        chk(run_target, 32'h0000_0111);
        tap(6);
        chk({positioning, set_index}, 11'h000);
        tap(1);
        chk({positioning, run_target}, 33'h1_0000_0111);
        for (i = 0; i < 60 && set_index !== 10'h001; i++) @(negedge clock);
        // The next set's target follows the index by one cycle.
        @(negedge clock);
        chk({positioning, run_target}, 33'h1_0000_0222);
        for (i = 0; i < 60 && prog_end !== 1'b1; i++) @(negedge clock);
        chk({prog_end, positioning, set_index}, 12'h801);
    endtask

    task t_home;
        op_mode = shear_seq_pkg::OP_MANUAL;
        home_hold = 1;
        repeat (15000) @(negedge clock);
        home_hold = 0;
        @(negedge clock);
        home_hold = 1;
        for (i = 0; i < 21000 && homing_active !== 1'b1; i++)
            @(negedge clock);
        home_hold = 0;
        chk(i > 19990, 1);
        chk(drive_plus, 1);
        for (i = 0; i < 100 && limit_pos !== 1'b1; i++) @(negedge clock);
        for (n = 0; n < 100 && drive_minus !== 1'b1; n++) @(negedge clock);
        chk(n >= 20, 1);
        chk(homing_active, 1);
        for (i = 0; i < 100 && homing_active === 1'b1; i++) @(negedge clock);
        @(negedge clock);
        chk({last_load, drive_minus}, {ref_value, 1'b0});
    endtask

    task t_home_sw;
        homing_mode = shear_seq_pkg::HOME_NEG_SW;
        ref_value = 32'h0000_0def;
        home_hold = 1;
        for (i = 0; i < 21000 && homing_active !== 1'b1; i++)
            @(negedge clock);
        home_hold = 0;
        chk(drive_minus, 1);
        for (n = 0; n < 100 && drive_minus === 1'b1; n++) @(negedge clock);
        chk({ref_point, limit_neg}, 2'b10);
        for (i = 0; i < 100 && homing_active === 1'b1; i++) @(negedge clock);
        @(negedge clock);
        chk({last_load, drive_plus}, {32'h0000_0def, 1'b0});
    endtask

    task t_jog;
        jog_hold = 1;
        repeat (3) @(negedge clock);
        chk({drive_plus, drive_fast}, 2'b10);
        for (i = 0; i < 11000 && drive_fast !== 1'b1; i++) @(negedge clock);
        chk(i > 9980, 1);
        jog_hold = 0;
        repeat (3) @(negedge clock);
        chk(drive_plus, 0);
    endtask

    task test_done;
        $display("failures=%0d samples_checked=%0d", failures,
            samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1;
        repeat (4) @(negedge clock);
        t_single();
        t_ref();
        t_program();
        t_home();
        t_home_sw();
        t_jog();
        test_done();
    end
endmodule
